// >>> hdl/sgss_params.svh
// Constants of the servo gain set selector
`ifndef SGSS_PARAMS_SVH
`define SGSS_PARAMS_SVH
// Timing: clock period and one millisecond, both in ns
`define SGSS_CLK_NS       4
`define SGSS_MS_NS        1000000
`define SGSS_HOST_WAIT_MS 2
// Ramp fraction: 256 steps from one set to the other
`define SGSS_FRAC_W       8
`define SGSS_STEPS        256
`define SGSS_K_FULL       9'h100
`define SGSS_K_ZERO       9'h000
// Register byte offsets
`define SGSS_OFF_RIPPLE   8'h00
`define SGSS_OFF_GSW      8'h04
`define SGSS_OFF_CTRL     8'h08
`define SGSS_OFF_STAT     8'h0c
`define SGSS_OFF_IST      8'h10
`define SGSS_OFF_ICLR     8'h14
`define SGSS_OFF_IEN      8'h18
`define SGSS_OFF_TIM      8'h20
`define SGSS_OFF_GAIN     8'h40
`define SGSS_NUM_TIM      4
`define SGSS_NUM_GAIN     14
`define SGSS_NUM_RAMP     5
`define SGSS_SET2_BASE    7
// Option word digits and codes
`define SGSS_DIG0         3:0
`define SGSS_DIG1         7:4
`define SGSS_RIP_ON       4'h1
`define SGSS_DET_ON       4'h0
`define SGSS_GSW_RESV     4'h1
`define SGSS_GSW_AUTO1    4'h2
`define SGSS_CA_COIN_ON   4'h0
`define SGSS_CA_COIN_OFF  4'h1
`define SGSS_CA_NEAR_ON   4'h2
`define SGSS_CA_NEAR_OFF  4'h3
`define SGSS_CA_REF_IDLE  4'h4
`define SGSS_CA_REF_ON    4'h5
// Control, status and event bit positions
`define SGSS_CTRL_RESET   0
`define SGSS_CTRL_LOADED  1
`define SGSS_ST_WARN      0
`define SGSS_ST_SET2      1
`define SGSS_ST_RAMP      2
`define SGSS_ST_MF        3
`define SGSS_ST_VALID     4
`define SGSS_EV_WARN      0
`define SGSS_EV_SWDONE    1
`define SGSS_EV_RESV      2
`define SGSS_NUM_EV       3
// Timer word indices
`define SGSS_TIM_WAIT1    0
`define SGSS_TIM_RAMP1    1
`define SGSS_TIM_WAIT2    2
`define SGSS_TIM_RAMP2    3
// Reset values
`define SGSS_OPT_RST      16'h0000
`define SGSS_TIM_RST      16'h0000
`define SGSS_SET_RST      {16'h03e8, 16'h01f4, 16'h0064, 16'h0064, 16'h0190, 16'h07d0, 16'h0190}
`endif

// >>> hdl/sgss_pkg.sv
// Types of the servo gain set selector
package sgss_pkg;
    // Control method of the axis
    typedef enum logic [1:0] {CM_POS, CM_SPD, CM_TRQ} sgss_mode_type;
    // Automatic switching sequence
    typedef enum logic [1:0] {AS_IDLE, AS_WAIT, AS_RAMP} sgss_auto_type;
    // Avalon-MM request from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } sgss_avs_req_type;
    // Axis state and the servo command gain-select bit
    typedef struct packed {
        logic          gain_sel;
        logic          ref_active;
        logic          motor_stopped;
        logic          coin;
        logic          near;
        logic          ref_filter_zero;
        logic          pos_ref_on;
        sgss_mode_type mode;
    } sgss_motion_type;
    // One gain set as presented to the loops
    typedef struct packed {
        logic [15:0] mf_corr;
        logic [15:0] mf_gain;
        logic [15:0] fric_gain;
        logic [15:0] trq_filt;
        logic [15:0] pos_gain;
        logic [15:0] spd_int;
        logic [15:0] spd_gain;
    } sgss_gain_set_type;
    // Millisecond timer state
    typedef struct packed {
        logic [15:0] cnt;
        logic        done;
    } sgss_tmr_type;
endpackage

// >>> hdl/sgss_blend.sv
// Linear blend between two gain words by a 0..256 fraction
`timescale 1ns/100ps
`include "sgss_params.svh"
module sgss_blend import sgss_pkg::*; (
    // Endpoints
    input  wire logic [15:0] a,
    input  wire logic [15:0] b,
    // Fraction, 256 means all b
    input  wire logic [8:0]  k,
    // Result
    output logic      [15:0] y
);
    logic signed [17:0] diff;   // b minus a
    logic signed [27:0] prod;   // Scaled difference

    // Result always lies between a and b, so 16 bits suffice
    always_comb begin
        diff = $signed({2'b00, b}) - $signed({2'b00, a});
        prod = 28'(diff) * 28'($signed({1'b0, k}));
        y    = 16'($signed({2'b00, a}) + 18'(prod >>> `SGSS_FRAC_W));
    end
endmodule // sgss_blend

// >>> hdl/sgss_timer.sv
// Millisecond down-counter for the switching wait time
`timescale 1ns/100ps
module sgss_timer import sgss_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Load and count
    input  wire logic        start,
    input  wire logic        ms_tick,
    input  wire logic [15:0] dur,
    // Expiry level
    output logic             done
);
    sgss_tmr_type s, n;   // State and next state

    // Load on start, count down one per millisecond tick
    always_comb begin
        n = s;
        if (start) begin
            n.cnt  = dur;
            n.done = (dur == 16'h0000);
        end else if (!s.done && ms_tick) begin
            n.cnt  = s.cnt - 16'h0001;
            n.done = (s.cnt <= 16'h0001);
        end
    end

    // Register the state
    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '{cnt: 16'h0000, done: 1'b1};
        end else begin
            s <= n;
        end
    end

    assign done = s.done;
endmodule // sgss_timer

// >>> hdl/sgss_top.sv
// Servo gain set selector with Avalon-MM registers and interrupt
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
// What this block does
// - Raise mismatch warning while compensation enabled
// - Clear warning on reset, disable, detect-off
// - Ripple digit two: 0 detects, 1 suppresses
// - Gain digit one: 0 manual, 2 automatic
// - Automatic only in position; manual everywhere
// - Manual by command bit, automatic internally
// - Model-following pair switches only when manual
// - Model-following pair moves only stopped, idle
// - Gain-select 0 picks set 1, 1 set 2
// - After wait, ramp gains linearly over time
// - Ripple digit one: 1 enables, 0 disables
`include "sgss_params.svh"
module sgss_top import sgss_pkg::*; #(
    parameter int MS_CYC = `SGSS_MS_NS / `SGSS_CLK_NS   // Cycles per millisecond
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Avalon-MM slave
    input  wire sgss_avs_req_type  avs_req,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // Axis state and stored-data check
    input  wire sgss_motion_type   motion,
    input  wire logic              ripple_data_mismatch,
    // Selected gains and interrupt
    output sgss_gain_set_type      active_gains,
    output logic                   irq
);
    localparam int STEP_CYC = MS_CYC / `SGSS_STEPS;     // Cycles per ramp tick
    localparam int DW       = $clog2(MS_CYC + 1);       // Millisecond divider width
    localparam int SW       = $clog2(STEP_CYC + 1);     // Ramp tick divider width

    // Whole state of the block
    typedef struct packed {
        logic                                wreq;      // Waitrequest
        logic [31:0]                         rdata;     // Read data
        logic [15:0]                         rip_opt;   // Ripple options word
        logic [15:0]                         gsw_opt;   // Gain switching options word
        logic [`SGSS_NUM_TIM-1:0][15:0]      tim;       // Wait and ramp times in ms
        logic [`SGSS_NUM_GAIN-1:0][15:0]     gw;        // Both gain sets
        logic                                valid;     // Compensation data stored
        logic                                warn;      // Mismatch warning
        logic                                mf_sel;    // Set of model-following pair
        logic                                dir;       // Automatic target, 1 is set 2
        sgss_auto_type                       fsm;       // Automatic sequence
        logic [8:0]                          k;         // Blend fraction
        logic [15:0]                         step_cnt;  // Ramp ticks per step
        logic [DW-1:0]                       ms_cnt;    // Millisecond divider
        logic [SW-1:0]                       st_cnt;    // Ramp tick divider
        logic                                ms_tick;   // Millisecond pulse
        logic                                st_tick;   // Ramp tick pulse
        logic [`SGSS_NUM_EV-1:0]             ists;      // Sticky events
        logic [`SGSS_NUM_EV-1:0]             ien;       // Event enables
        logic [6:0][15:0]                    outw;      // Presented gains
        logic                                irq;       // Interrupt line
    } sgss_state_type;

    sgss_state_type               s, n;        // State and next state
    logic [`SGSS_NUM_RAMP-1:0][15:0] blend;    // Blended ramped words
    logic                         tmr_start;   // Load wait timer
    logic [15:0]                  tmr_dur;     // Wait time to load
    logic                         tmr_done;    // Wait expired
    logic                         ca;          // Condition A
    logic                         auto_mode;   // Automatic pattern selected
    logic                         rip_en;      // Compensation enabled
    logic                         det_en;      // Warning detection enabled
    logic [15:0]                  ramp_ms;     // Ramp time of current direction
    logic [8:0]                   k_tgt;       // Fraction at the target set

    // Merge byte lanes into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Option decodes
    assign auto_mode = (s.gsw_opt[`SGSS_DIG0] == `SGSS_GSW_AUTO1);
    assign rip_en    = (s.rip_opt[`SGSS_DIG0] == `SGSS_RIP_ON);
    assign det_en    = (s.rip_opt[`SGSS_DIG1] == `SGSS_DET_ON);
    assign ramp_ms   = s.dir ? s.tim[`SGSS_TIM_RAMP1] : s.tim[`SGSS_TIM_RAMP2];
    assign k_tgt     = s.dir ? `SGSS_K_FULL : `SGSS_K_ZERO;

    // Condition A chosen by the second gain switching digit
    always_comb begin
        case (s.gsw_opt[`SGSS_DIG1])
            `SGSS_CA_COIN_ON:  ca = motion.coin;
            `SGSS_CA_COIN_OFF: ca = !motion.coin;
            `SGSS_CA_NEAR_ON:  ca = motion.near;
            `SGSS_CA_NEAR_OFF: ca = !motion.near;
            `SGSS_CA_REF_IDLE: ca = motion.ref_filter_zero && !motion.pos_ref_on;
            `SGSS_CA_REF_ON:   ca = motion.pos_ref_on;
            default:           ca = 1'b0;
        endcase
    end

    // Ramped words of both sets, one blend per parameter
    generate
        for (genvar gi = 0; gi < `SGSS_NUM_RAMP; gi++) begin : g_blend
            sgss_blend u_blend (
                .a (s.gw[gi]),
                .b (s.gw[gi + `SGSS_SET2_BASE]),
                .k (s.k),
                .y (blend[gi])
            );
        end
    endgenerate

    // Wait timer in milliseconds
    sgss_timer u_timer (
        .clk     (clk),
        .srst    (srst),
        .start   (tmr_start),
        .ms_tick (s.ms_tick),
        .dur     (tmr_dur),
        .done    (tmr_done)
    );

    // Next state of the whole block
    always_comb begin
        logic [`SGSS_NUM_EV-1:0] ev;    // Events this cycle
        logic [`SGSS_NUM_EV-1:0] clr;   // Software clears this cycle
        logic [31:0]             rd;    // Read mux
        logic [15:0]             wgsw;  // Merged gain options write
        ev        = '0;
        clr       = '0;
        rd        = '0;
        wgsw      = merge16(s.gsw_opt, avs_req.writedata, avs_req.byteenable);
        n         = s;
        tmr_start = 1'b0;
        tmr_dur   = ca ? s.tim[`SGSS_TIM_WAIT1] : s.tim[`SGSS_TIM_WAIT2];

        // Millisecond and ramp tick dividers
        n.ms_tick = 1'b0;
        n.st_tick = 1'b0;
        if (s.ms_cnt == DW'(MS_CYC - 1)) begin
            n.ms_cnt  = '0;
            n.ms_tick = 1'b1;
        end else begin
            n.ms_cnt = s.ms_cnt + 1'b1;
        end
        if (s.st_cnt == SW'(STEP_CYC - 1)) begin
            n.st_cnt  = '0;
            n.st_tick = 1'b1;
        end else begin
            n.st_cnt = s.st_cnt + 1'b1;
        end

        // Read mux, unmapped and write-only words read zero
        case (avs_req.address)
            `SGSS_OFF_RIPPLE: rd[15:0] = s.rip_opt;
            `SGSS_OFF_GSW:    rd[15:0] = s.gsw_opt;
            `SGSS_OFF_STAT: begin
                rd[`SGSS_ST_WARN]  = s.warn;
                rd[`SGSS_ST_SET2]  = (s.k == `SGSS_K_FULL);
                rd[`SGSS_ST_RAMP]  = (s.fsm == AS_RAMP);
                rd[`SGSS_ST_MF]    = s.mf_sel;
                rd[`SGSS_ST_VALID] = s.valid;
            end
            `SGSS_OFF_IST:    rd[`SGSS_NUM_EV-1:0] = s.ists;
            `SGSS_OFF_IEN:    rd[`SGSS_NUM_EV-1:0] = s.ien;
            default: ;
        endcase
        for (int i = 0; i < `SGSS_NUM_TIM; i++) begin
            if (avs_req.address == `SGSS_OFF_TIM + 8'(4 * i)) begin
                rd[15:0] = s.tim[i];
            end
        end
        for (int i = 0; i < `SGSS_NUM_GAIN; i++) begin
            if (avs_req.address == `SGSS_OFF_GAIN + 8'(4 * i)) begin
                rd[15:0] = s.gw[i];
            end
        end

        // Bus handshake: waitrequest drops for one cycle after a request
        n.wreq = 1'b1;
        if ((avs_req.read || avs_req.write) && s.wreq) begin
            n.wreq  = 1'b0;
            n.rdata = rd;
        end

        // Writes take effect at the edge where waitrequest is low
        if (avs_req.write && !s.wreq) begin
            case (avs_req.address)
                `SGSS_OFF_RIPPLE: n.rip_opt = merge16(s.rip_opt, avs_req.writedata, avs_req.byteenable);
                `SGSS_OFF_GSW: begin
                    n.gsw_opt = wgsw;
                    // Reserved mode is flagged and then runs as manual
                    if (wgsw[`SGSS_DIG0] == `SGSS_GSW_RESV) begin
                        ev[`SGSS_EV_RESV] = 1'b1;
                    end
                end
                `SGSS_OFF_CTRL: begin
                    if (avs_req.byteenable[0] && avs_req.writedata[`SGSS_CTRL_RESET]) begin
                        n.valid = 1'b0;
                    end else if (avs_req.byteenable[0] && avs_req.writedata[`SGSS_CTRL_LOADED]) begin
                        n.valid = 1'b1;
                    end
                end
                `SGSS_OFF_ICLR: begin
                    if (avs_req.byteenable[0]) begin
                        clr = avs_req.writedata[`SGSS_NUM_EV-1:0];
                    end
                end
                `SGSS_OFF_IEN: begin
                    if (avs_req.byteenable[0]) begin
                        n.ien = avs_req.writedata[`SGSS_NUM_EV-1:0];
                    end
                end
                default: ;
            endcase
            for (int i = 0; i < `SGSS_NUM_TIM; i++) begin
                if (avs_req.address == `SGSS_OFF_TIM + 8'(4 * i)) begin
                    n.tim[i] = merge16(s.tim[i], avs_req.writedata, avs_req.byteenable);
                end
            end
            for (int i = 0; i < `SGSS_NUM_GAIN; i++) begin
                if (avs_req.address == `SGSS_OFF_GAIN + 8'(4 * i)) begin
                    n.gw[i] = merge16(s.gw[i], avs_req.writedata, avs_req.byteenable);
                end
            end
        end

        // Mismatch warning holds only while enabled, detected and data stored
        n.warn = rip_en && det_en && s.valid && (s.warn || ripple_data_mismatch);
        ev[`SGSS_EV_WARN] = n.warn && !s.warn;

        // Gain set selection
        if (!auto_mode) begin
            // Manual: command bit steps every ramped word at once
            n.fsm = AS_IDLE;
            n.dir = motion.gain_sel;
            n.k   = motion.gain_sel ? `SGSS_K_FULL : `SGSS_K_ZERO;
            // Model-following pair only moves when stopped with no reference
            if (!motion.ref_active && motion.motor_stopped) begin
                n.mf_sel = motion.gain_sel;
            end
        end else if (motion.mode != CM_POS) begin
            // No automatic switching outside position control
            n.fsm = AS_IDLE;
            n.dir = s.gsw_opt[4];
            n.k   = s.gsw_opt[4] ? `SGSS_K_FULL : `SGSS_K_ZERO;
        end else begin
            unique case (s.fsm)
                // Wait for condition A to differ from the held set
                AS_IDLE: begin
                    if (ca != s.dir || s.k != k_tgt) begin
                        n.dir     = ca;
                        n.fsm     = AS_WAIT;
                        tmr_start = 1'b1;
                    end
                end
                // Waiting time, restarted if the condition flips
                AS_WAIT: begin
                    if (ca != s.dir) begin
                        n.dir     = ca;
                        tmr_start = 1'b1;
                    end else if (tmr_done) begin
                        n.fsm      = AS_RAMP;
                        n.step_cnt = '0;
                    end
                end
                // Linear ramp, one fraction step per ramp_ms ticks
                AS_RAMP: begin
                    if (ca != s.dir) begin
                        n.dir     = ca;
                        n.fsm     = AS_WAIT;
                        tmr_start = 1'b1;
                    end else if (s.k == k_tgt) begin
                        n.fsm                 = AS_IDLE;
                        ev[`SGSS_EV_SWDONE]   = 1'b1;
                    end else if (ramp_ms == 16'h0000) begin
                        n.k = k_tgt;
                    end else if (s.st_tick) begin
                        if (s.step_cnt + 16'h0001 >= ramp_ms) begin
                            n.step_cnt = '0;
                            n.k        = s.dir ? s.k + 9'h001 : s.k - 9'h001;
                        end else begin
                            n.step_cnt = s.step_cnt + 16'h0001;
                        end
                    end
                end
            endcase
        end

        // Registered presentation of the selected set
        for (int i = 0; i < `SGSS_NUM_RAMP; i++) begin
            n.outw[i] = blend[i];
        end
        for (int i = `SGSS_NUM_RAMP; i < `SGSS_SET2_BASE; i++) begin
            n.outw[i] = s.mf_sel ? s.gw[i + `SGSS_SET2_BASE] : s.gw[i];
        end

        // Sticky events, a set wins over a clear in the same cycle
        n.ists = (s.ists & ~clr) | ev;
        n.irq  = |(n.ists & n.ien);
    end

    // Register the state
    always_ff @(posedge clk) begin
        if (srst) begin
            s          <= '0;
            s.wreq     <= 1'b1;
            s.rip_opt  <= `SGSS_OPT_RST;
            s.gsw_opt  <= `SGSS_OPT_RST;
            s.tim      <= {`SGSS_NUM_TIM{`SGSS_TIM_RST}};
            s.gw       <= {`SGSS_SET_RST, `SGSS_SET_RST};
            s.outw     <= `SGSS_SET_RST;
            s.fsm      <= AS_IDLE;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state
    assign avs_readdata    = s.rdata;
    assign avs_waitrequest = s.wreq;
    assign active_gains    = s.outw;
    assign irq             = s.irq;

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    AST_WARN_SET: assert property (rip_en && det_en && s.valid && ripple_data_mismatch |=> s.warn)
        else $error("Mismatch warning not raised");
    AST_WARN_CLR: assert property (!(rip_en && det_en && s.valid) |=> !s.warn)
        else $error("Mismatch warning not cleared");
    AST_DET_OFF: assert property ((s.rip_opt[`SGSS_DIG1] != `SGSS_DET_ON)[*2] |-> !s.warn)
        else $error("Warning raised with detection off");
    AST_MANUAL_SET2: assert property (!auto_mode && motion.gain_sel |=> s.k == `SGSS_K_FULL ##1
        active_gains.pos_gain == $past(s.gw[`SGSS_SET2_BASE + 2]))
        else $error("Manual select did not present set 2");
    AST_NONPOS_FIXED: assert property (auto_mode && motion.mode != CM_POS && !s.gsw_opt[4]
        |=> s.k == `SGSS_K_ZERO && s.fsm == AS_IDLE)
        else $error("Automatic switching outside position control");
    AST_MF_AUTO: assert property (auto_mode |=> s.mf_sel == $past(s.mf_sel))
        else $error("Model-following set moved in automatic mode");
    AST_MF_MOVING: assert property (motion.ref_active || !motion.motor_stopped |=> $stable(s.mf_sel))
        else $error("Model-following set moved while running");
    AST_RAMP_UP: assert property (s.fsm == AS_RAMP && s.dir && ca && auto_mode && motion.mode == CM_POS
        |=> s.k >= $past(s.k))
        else $error("Ramp toward set 2 went backwards");
    AST_BUS_ACK: assert property ((avs_req.read || avs_req.write) && s.wreq
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("Waitrequest not low for exactly one cycle");

    COV_MANUAL: cover property (!auto_mode && $rose(s.k[8]));
    COV_RAMP_DONE: cover property (s.fsm == AS_RAMP ##1 s.fsm == AS_IDLE && s.dir);
    COV_WARN: cover property ($rose(s.warn));
endmodule // sgss_top

// >>> bench/sgss_host_model.sv
// Host motion controller model driving the axis levels
`timescale 1ns/100ps
module sgss_host_model import sgss_pkg::*; #(
    parameter int HOLD = 1024                // Cycles of the post-select pause
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            srst,
    // Wanted axis state and what reaches the block
    input  wire sgss_motion_type cmd,
    output sgss_motion_type      motion
);
    logic [15:0] hold_r;                     // Pause counter after a select change
    // Register commands; a new reference waits out the pause
    always_ff @(posedge clk) begin
        if (srst) begin
            motion <= '0;
            hold_r <= '0;
        end else begin
            motion <= cmd;
            if (cmd.gain_sel != motion.gain_sel) hold_r <= 16'(HOLD);
            else if (hold_r != 16'h0000) hold_r <= hold_r - 16'h0001;
            if (hold_r != 16'h0000 && !motion.ref_active) motion.ref_active <= 1'b0;
        end
    end
endmodule // sgss_host_model

// >>> bench/testbench.sv
// Self-checking bench of the gain set selector
`timescale 1ns/100ps
`include "sgss_params.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench import sgss_pkg::*;;
    logic clk, srst, irq, avs_waitrequest, mism;
    logic [31:0] avs_readdata, rdv;
    sgss_avs_req_type req;
    sgss_motion_type cmd, motion;
    sgss_gain_set_type active_gains, s1, s2, mx;
    int errors = 0, samples_checked = 0;
    sgss_top #(.MS_CYC(512)) sgss_top_inst (.clk(clk), .srst(srst), .avs_req(req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .motion(motion), .ripple_data_mismatch(mism),
        .active_gains(active_gains), .irq(irq));
    sgss_host_model sgss_host_model_inst (.clk(clk), .srst(srst), .cmd(cmd), .motion(motion));
    // Clock of 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // One Avalon access, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= '{~w, w, a, 4'hf, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic summarize();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Reset values and an unmapped address
    task automatic t_reset();
        `CHK("gains", s1, active_gains)
        acc(0, `SGSS_OFF_GSW, 0); `CHK("gsw", 32'h0, rdv)
        acc(0, 8'h3c, 0); `CHK("unmapped", 32'h0, rdv)
    endtask
    // Manual select and the stopped-only model-following pair
    task automatic t_manual();
        for (int i = 0; i < 7; i++) acc(1, 8'(`SGSS_OFF_GAIN + 4 * (7 + i)), 32'h0a07 + i);
        cmd.motor_stopped <= 1'b1; cmd.gain_sel <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("set2", s2, active_gains)
        // The host holds back a reference for 2 ms after a select change
        repeat (1030) @(posedge clk);
        cmd.ref_active <= 1'b1;
        repeat (3) @(posedge clk);
        cmd.gain_sel <= 1'b0;
        repeat (6) @(posedge clk);
        mx = s1; mx.mf_gain = s2.mf_gain; mx.mf_corr = s2.mf_corr;
        `CHK("mf held", mx, active_gains)
        cmd.ref_active <= 1'b0;
        repeat (1100) @(posedge clk);
        `CHK("mf back", s1, active_gains)
    endtask
    // Automatic switch leaves the pair, no switch outside position
    task automatic t_auto();
        acc(1, `SGSS_OFF_TIM, 32'h1); acc(1, 8'(`SGSS_OFF_TIM + 4), 32'h2);
        acc(1, `SGSS_OFF_GSW, 32'h2); cmd.coin <= 1'b1;
        repeat (600) @(posedge clk);
        acc(0, `SGSS_OFF_STAT, 0); `CHK("ramping", 1'b1, rdv[2])
        `CHK("mid", 1'b1, active_gains.pos_gain > s1.pos_gain && active_gains.pos_gain < s2.pos_gain)
        repeat (1100) @(posedge clk);
        mx = s2; mx.mf_gain = s1.mf_gain; mx.mf_corr = s1.mf_corr;
        `CHK("auto", mx, active_gains)
        acc(0, `SGSS_OFF_IST, 0); `CHK("done ev", 1'b1, rdv[1])
        cmd.mode <= CM_SPD;
        repeat (6) @(posedge clk);
        `CHK("spd mode", s1, active_gains)
    endtask
    // Warning raise, suppress, disable and interrupt clear
    task automatic t_warn();
        acc(1, `SGSS_OFF_IEN, 32'h1); acc(1, `SGSS_OFF_RIPPLE, 32'h1); acc(1, `SGSS_OFF_CTRL, 32'h2);
        mism <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        acc(1, `SGSS_OFF_RIPPLE, 32'h11); acc(0, `SGSS_OFF_STAT, 0); `CHK("det off", 1'b0, rdv[0])
        acc(1, `SGSS_OFF_RIPPLE, 32'h1); acc(0, `SGSS_OFF_STAT, 0); `CHK("det on", 1'b1, rdv[0])
        acc(1, `SGSS_OFF_CTRL, 32'h1); acc(0, `SGSS_OFF_STAT, 0); `CHK("val rst", 2'b00, {rdv[4], rdv[0]})
        acc(1, `SGSS_OFF_CTRL, 32'h2); acc(1, `SGSS_OFF_RIPPLE, 32'h0);
        acc(0, `SGSS_OFF_STAT, 0); `CHK("disabled", 1'b0, rdv[0])
        acc(1, `SGSS_OFF_ICLR, 32'h7); `CHK("irq clr", 1'b0, irq)
    endtask
    // Main sequence
    initial begin
        srst = 1'b1; req = '0; cmd = '0; mism = 1'b0;
        s1 = `SGSS_SET_RST;
        s2 = '{16'h0a0d, 16'h0a0c, 16'h0a0b, 16'h0a0a, 16'h0a09, 16'h0a08, 16'h0a07};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset(); t_manual(); t_auto(); t_warn();
        summarize();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end
endmodule // testbench
